/* File: hdl/liu_irq_pkg.sv */
// package for the line interface channel interrupt enable block
// assumes a 32-bit axi4-lite register bus, one aligned word per register
package liu_irq_pkg;
   // register byte offsets
   localparam logic [7:0] ENABLE_OFFSET = 8'h04;
   localparam logic [7:0] STATUS_OFFSET = 8'h08;
   localparam logic [7:0] EVENT_OFFSET = 8'h0c;
   localparam logic [7:0] CONTROL_OFFSET = 8'h10;
   // enable, event and control bit positions
   localparam int TEST_PATTERN_BIT = 0;
   localparam int SIGNAL_LOSS_BIT = 1;
   localparam int ALARM_SIGNAL_BIT = 2;
   localparam int LOOP_CODE_BIT = 3;
   localparam int CODE_VIOLATION_BIT = 4;
   localparam int SINGLE_RAIL_BIT = 0;
   localparam int FRAMER_BYPASS_BIT = 1;
   localparam int EVENT_WIDTH = 5;
   // reset values
   localparam logic [7:0] ENABLE_RESET = 8'h00;
   localparam logic [1:0] CONTROL_RESET = 2'h0;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : liu_irq_pkg

/* File: hdl/liu_reg_if.sv */
// interface carrying one register access from the bus slave to the core
// assumes a single clock domain
`timescale 1ns/1ps
interface liu_reg_if;
   logic wr_en;
   logic rd_en;
   logic [7:0] addr;
   logic [31:0] wdata;
   logic [3:0] wstrb;
   logic [31:0] rdata;
   logic err;
   modport slave (output wr_en, rd_en, addr, wdata, wstrb, input rdata, err);
   modport core (input wr_en, rd_en, addr, wdata, wstrb, output rdata, err);
endinterface : liu_reg_if

/* File: hdl/liu_axi_slave.sv */
// axi4-lite slave that turns bus transfers into single-cycle register accesses
// assumes aclk only and synchronous active low reset
`timescale 1ns/1ps
module liu_axi_slave
   import liu_irq_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   liu_reg_if.slave regs
);
   logic aw_held_q;
   logic w_held_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic do_write;
   logic do_read;

   // channels are taken once and held until the write can run
   assign awready = !aw_held_q && !bvalid;
   assign wready = !w_held_q && !bvalid;
   assign arready = !rvalid && !do_write; // a read waits out a running write, so it is never taken and lost
   assign do_write = aw_held_q && w_held_q && !bvalid;
   assign do_read = arvalid && arready;

   // capture write address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         awaddr_q <= 8'h00;
      end else if (awvalid && awready) begin
         aw_held_q <= 1'b1;
         awaddr_q <= awaddr;
      end else if (do_write) begin
         aw_held_q <= 1'b0;
      end
   end

   // capture write data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_q <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else if (wvalid && wready) begin
         w_held_q <= 1'b1;
         wdata_q <= wdata;
         wstrb_q <= wstrb;
      end else if (do_write) begin
         w_held_q <= 1'b0;
      end
   end

   // register access strobes toward the core
   assign regs.wr_en = do_write;
   assign regs.rd_en = do_read;
   assign regs.addr = do_write ? awaddr_q : araddr;
   assign regs.wdata = wdata_q;
   assign regs.wstrb = wstrb_q;

   // write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else if (do_write) begin
         bvalid <= 1'b1;
         bresp <= regs.err ? RESP_SLVERR : RESP_OKAY;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // read response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rresp <= RESP_OKAY;
         rdata <= 32'h0000_0000;
      end else if (do_read && !do_write) begin
         rvalid <= 1'b1;
         rresp <= regs.err ? RESP_SLVERR : RESP_OKAY;
         rdata <= regs.rdata;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end
endmodule : liu_axi_slave

/* File: hdl/liu_channel_interrupt_enables.sv */
// line interface channel interrupt enables, status and request
// assumes condition inputs synchronous to aclk; axi4-lite slave for software
//
// Notes on behaviour
// - bit 4 enables code violation interrupts; one enables, zero masks, resets zero
// - bit 3 enables interrupts on start and end of loop code detection
// - bit 2 enables alarm signal interrupts; meant for framer bypass only
// - bit 1 enables interrupts on loss of signal declare and clear
// - bit 0 enables interrupts on start and end of test pattern detection
// - these registers work only in single-rail mode; framer must match
// - code violation status follows receiver; every transition makes an event; the logic only counts it with framer bypass set too
//
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module liu_channel_interrupt_enables
   import liu_irq_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic code_violation_in,
   input wire logic loop_code_detect_in,
   input wire logic alarm_signal_in,
   input wire logic signal_loss_in,
   input wire logic test_pattern_in,
   output logic irq
);
   liu_reg_if regs ();

   // ****************************************
   // bus slave
   // ****************************************
   liu_axi_slave u_slave (
      .aclk(aclk),
      .aresetn(aresetn),
      .awaddr(awaddr),
      .awvalid(awvalid),
      .awready(awready),
      .wdata(wdata),
      .wstrb(wstrb),
      .wvalid(wvalid),
      .wready(wready),
      .bresp(bresp),
      .bvalid(bvalid),
      .bready(bready),
      .araddr(araddr),
      .arvalid(arvalid),
      .arready(arready),
      .rdata(rdata),
      .rresp(rresp),
      .rvalid(rvalid),
      .rready(rready),
      .regs(regs)
   );

   // ****************************************
   // registers and state
   // ****************************************
   logic [7:0] enable_q;
   logic [1:0] control_q;
   logic [EVENT_WIDTH-1:0] level_q;
   logic [EVENT_WIDTH-1:0] event_q;
   logic [EVENT_WIDTH-1:0] level_now;
   logic [EVENT_WIDTH-1:0] change;
   logic [EVENT_WIDTH-1:0] gate;
   logic single_rail;
   logic bypass;
   logic event_read;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a[7:2] == off[7:2]);
   endfunction : hit

   assign single_rail = control_q[SINGLE_RAIL_BIT];
   assign bypass = control_q[FRAMER_BYPASS_BIT];
   assign level_now = {code_violation_in, loop_code_detect_in, alarm_signal_in,
                       signal_loss_in, test_pattern_in};

   // enable register, byte lane 0 only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enable_q <= ENABLE_RESET;
      end else if (regs.wr_en && hit(regs.addr, ENABLE_OFFSET) && regs.wstrb[0]) begin
         enable_q <= regs.wdata[7:0];
      end
   end

   // mode control: single rail and framer bypass
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         control_q <= CONTROL_RESET;
      end else if (regs.wr_en && hit(regs.addr, CONTROL_OFFSET) && regs.wstrb[0]) begin
         control_q <= regs.wdata[1:0];
      end
   end

   // sampled condition levels; status follows the receiver
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         level_q <= '0;
      end else begin
         level_q <= level_now;
      end
   end

   // any transition of a condition is a change event
   assign change = level_now ^ level_q;

   // events count only in single-rail mode; violation and alarm need bypass
   always_comb begin
      gate = {EVENT_WIDTH{single_rail}};
      gate[CODE_VIOLATION_BIT] = single_rail && bypass;
      gate[ALARM_SIGNAL_BIT] = single_rail && bypass;
   end

   assign event_read = regs.rd_en && hit(regs.addr, EVENT_OFFSET);

   // sticky events, cleared by reading; a new event beats the clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         event_q <= '0;
      end else begin
         event_q <= (event_read ? '0 : event_q) | (change & gate);
      end
   end

   // interrupt only from enabled events
   assign irq = |(event_q & enable_q[EVENT_WIDTH-1:0]);

   // read mux and unmapped decode
   always_comb begin
      regs.rdata = 32'h0000_0000;
      regs.err = 1'b0;
      if (hit(regs.addr, ENABLE_OFFSET)) begin
         regs.rdata[7:0] = enable_q;
      end else if (hit(regs.addr, STATUS_OFFSET)) begin
         regs.rdata[EVENT_WIDTH-1:0] = level_q;
      end else if (hit(regs.addr, EVENT_OFFSET)) begin
         regs.rdata[EVENT_WIDTH-1:0] = event_q;
      end else if (hit(regs.addr, CONTROL_OFFSET)) begin
         regs.rdata[1:0] = control_q;
      end else begin
         regs.err = 1'b1;
      end
   end
endmodule : liu_channel_interrupt_enables

/* File: bench/liu_irq_sva.sv */
// assertions for the channel interrupt enable block
// assumes binding onto the ports of its top module
`timescale 1ns/1ps
module liu_irq_sva (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awready,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic code_violation_in,
   input wire logic loop_code_detect_in,
   input wire logic alarm_signal_in,
   input wire logic signal_loss_in,
   input wire logic test_pattern_in,
   input wire logic irq
);
   // ***************
   // properties
   // ***************
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [4:0] cond;
   // condition inputs gathered for change detection
   assign cond = {code_violation_in, loop_code_detect_in, alarm_signal_in, signal_loss_in, test_pattern_in};
   chk_b_hold: assert property (bvalid && !bready |=> bvalid) else $error("bvalid dropped");
   chk_b_done: assert property (bvalid && bready |=> !bvalid) else $error("bvalid stuck");
   chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read moved");
   chk_b_busy: assert property (bvalid |-> !awready && !wready) else $error("write taken busy");
   chk_r_busy: assert property (rvalid |-> !arready) else $error("read taken busy");
   chk_resp_code: assert property (bvalid |-> bresp inside {2'h0, 2'h2}) else $error("bad bresp");
   chk_err_zero: assert property (rvalid && rresp == 2'h2 |-> rdata == 0) else $error("error data");
   chk_irq_cause: assert property ($rose(irq) |-> $past(cond) != $past(cond, 2) || $rose(bvalid))
      else $error("irq without cause");
   chk_irq_clear: assert property ($fell(irq) |-> $rose(rvalid) || $rose(bvalid))
      else $error("irq fell alone");
   // main scenarios
   cover property ($rose(irq));
   cover property ($fell(irq));
   cover property (rvalid && rresp == 2'h2);
   cover property (rvalid && !rready);
endmodule : liu_irq_sva
bind liu_channel_interrupt_enables liu_irq_sva chk (.*);

/* File: bench/tb.sv */
// self-checking bench for the channel interrupt enable block
// assumes the block alone, driven through its axi4-lite port
`timescale 1ns/1ps
module tb
   import liu_irq_pkg::*;
;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, d;
   logic [3:0] wstrb = 4'hf;
   logic [4:0] cond = 0;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp, resp;
   int fails = 0, n_tests = 0;
   int slow = 0; // cycles the master lets a response stand before taking it
   // 200 MHz clock
   always #2.5 aclk = ~aclk;
   liu_channel_interrupt_enables dut (.*, .code_violation_in(cond[4]), .loop_code_detect_in(cond[3]),
      .alarm_signal_in(cond[2]), .signal_loss_in(cond[1]), .test_pattern_in(cond[0]));
   // ***************
   // tasks
   // ***************
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // one write, address and data together, waits for the response
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      int late;
      late = slow;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1;
      wvalid <= 1;
      bready <= (late == 0);
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
         if (bvalid && late > 0) late--;
         if (late == 0 && !bready) bready <= 1;
      end while (!(bvalid && bready));
      bready <= 0;
      resp = bresp;
   endtask : wr
   // one read, waits for the data
   task automatic rd(input logic [7:0] a);
      int late;
      late = slow;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      rready <= (late == 0);
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 0;
         if (rvalid && late > 0) late--;
         if (late == 0 && !rready) rready <= 1;
      end while (!(rvalid && rready));
      rready <= 0;
      d = rdata;
      resp = rresp;
   endtask : rd
   // flips one condition and lets the event land
   task automatic tg(input int b);
      @(posedge aclk);
      cond[b] <= ~cond[b];
      repeat (2) @(posedge aclk);
   endtask : tg
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : print_verdict
   // ***************
   // tests
   // ***************
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1;
      rd(ENABLE_OFFSET);
      chk("enable", 0, d);
      rd(8'h20);
      chk("rresp", RESP_SLVERR, resp);
      wr(8'h20, 32'h0000_0001);
      chk("bresp", RESP_SLVERR, resp);
      $display("test reset done");
      wr(CONTROL_OFFSET, 32'h0000_0003);
      rd(CONTROL_OFFSET);
      chk("control", 32'h0000_0003, d);
      for (int b = 0; b < EVENT_WIDTH; b++) begin
         wr(ENABLE_OFFSET, 1 << b);
         rd(ENABLE_OFFSET);
         chk("enable", 1 << b, d);
         repeat (2) begin
            tg(b);
            chk("irq set", 1, irq);
            rd(EVENT_OFFSET);
            chk("event", 1 << b, d);
            chk("irq clear", 0, irq);
         end
         slow = 2;
         wr(ENABLE_OFFSET, 32'h0000_00e0);
         tg(b);
         chk("irq masked", 0, irq);
         rd(STATUS_OFFSET);
         slow = 0;
         chk("status", cond, d);
         rd(EVENT_OFFSET);
         chk("masked event", 1 << b, d);
      end
      $display("test events done");
      wr(CONTROL_OFFSET, 32'h0000_0002);
      wr(ENABLE_OFFSET, 32'h0000_001f);
      for (int b = 0; b < EVENT_WIDTH; b++) tg(b);
      chk("irq rail", 0, irq);
      rd(EVENT_OFFSET);
      chk("rail event", 0, d);
      wr(CONTROL_OFFSET, 32'h0000_0001);
      for (int b = 0; b < EVENT_WIDTH; b++) tg(b);
      chk("irq bypass", 1, irq);
      rd(EVENT_OFFSET);
      chk("bypass event", 32'h0000_000b, d);
      $display("test gating done");
      print_verdict();
   end
   // watchdog against a hung handshake
   initial begin
      #100000;
      fails++;
      print_verdict();
   end
endmodule : tb
